// file: src/tdd_converter_device.sv
`timescale 1ns/1ps
module tdd_converter_device
    import tdd_port_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    tdd_port_if.device             port,
    input  wire logic signed [4:0] adc_analog_code,
    output logic signed [6:0]      dac_analog_level,
    output logic                   dac_active,
    output logic                   adc_active,
    output logic                   device_ready
);
    op_mode_t    mode;
    logic        clk_d_reg;
    logic        fall;
    logic        rise;
    logic [6:0]  dac_hold_reg;
    logic [4:0]  adc_sample_reg;
    logic [4:0]  adc_out_reg;
    logic [4:0]  oe_n_reg;
    logic [15:0] wake_cnt_reg;

    always_comb begin
        case ({port.receive_enable, port.transmit_enable})
            2'b10:   mode = MODE_RECEIVE;
            2'b01:   mode = MODE_TRANSMIT;
            default: mode = MODE_SHUTDOWN;
        endcase
    end

    // edges of the converter clock; clock may run in shutdown harmlessly
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            clk_d_reg <= 1'b0;
        else
            clk_d_reg <= port.conv_clk;
    end
    assign fall = clk_d_reg & ~port.conv_clk;
    assign rise = ~clk_d_reg & port.conv_clk;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            wake_cnt_reg <= 16'h0000;
        else if (mode == MODE_SHUTDOWN)
            wake_cnt_reg <= 16'h0000;
        else if (wake_cnt_reg != 16'(WAKE_CYCLES))
            wake_cnt_reg <= wake_cnt_reg + 16'h0001;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            device_ready <= 1'b0;
        else
            device_ready <= (mode != MODE_SHUTDOWN) &&
                            (wake_cnt_reg == 16'(WAKE_CYCLES));
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            dac_hold_reg <= DAC_ZERO;
        else if (mode == MODE_TRANSMIT && fall)
            dac_hold_reg <= {port.dac_data_msb, port.dac_data_bit_five,
                             port.shared_data_low};
    end

    // signed output level: 3F is +full, 40 is -full
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            dac_analog_level <= DAC_ZERO;
        else if (mode != MODE_TRANSMIT)
            dac_analog_level <= DAC_ZERO;
        else if (rise)
            dac_analog_level <= dac_hold_reg;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            adc_sample_reg <= ADC_ZERO;
        else if (mode == MODE_RECEIVE && fall)
            adc_sample_reg <= adc_analog_code;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            adc_out_reg <= ADC_ZERO;
        else if (mode != MODE_RECEIVE)
            adc_out_reg <= ADC_ZERO;
        else if (rise)
            adc_out_reg <= adc_sample_reg;
    end
    assign port.low_dev_out = adc_out_reg;

    // released lines in shutdown avoid driving into a host that holds them low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            oe_n_reg <= 5'h1F;
        else
            oe_n_reg <= (mode == MODE_RECEIVE) ? 5'h00 : 5'h1F;
    end
    assign port.low_dev_oe_n = oe_n_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dac_active <= 1'b0;
            adc_active <= 1'b0;
        end else begin
            dac_active <= (mode == MODE_TRANSMIT);
            adc_active <= (mode == MODE_RECEIVE);
        end
    end
endmodule

// file: src/tdd_port_pkg.sv
package tdd_port_pkg;
    localparam int DAC_W          = 7;
    localparam int ADC_W          = 5;
    localparam int LOW_W          = 5;
    localparam int CLK_PERIOD_PS  = 4000;
    localparam int WAKE_TIME_NS_X10 = 24;
    // wake time 2.4 us rounded up to whole mclk cycles
    localparam int WAKE_CYCLES    = (WAKE_TIME_NS_X10 * 100000 + CLK_PERIOD_PS - 1)
                                    / CLK_PERIOD_PS;
    localparam int CONV_DIV       = 8;
    localparam logic [6:0] DAC_POS_FS = 7'h3F;
    localparam logic [6:0] DAC_ZERO   = 7'h00;
    localparam logic [6:0] DAC_NEG_FS = 7'h40;
    localparam logic [4:0] ADC_ZERO   = 5'h00;
    typedef enum logic [1:0] {
        MODE_SHUTDOWN,
        MODE_TRANSMIT,
        MODE_RECEIVE
    } op_mode_t;
endpackage

// file: src/tdd_port_if.sv
`timescale 1ns/1ps
interface tdd_port_if;
    logic       receive_enable;
    logic       transmit_enable;
    logic       conv_clk;
    logic       dac_data_msb;
    logic       dac_data_bit_five;
    logic [4:0] low_host_out;
    logic [4:0] low_host_oe_n;
    logic [4:0] low_dev_out;
    logic [4:0] low_dev_oe_n;
    logic [4:0] shared_data_low;
    always_comb begin
        for (int i = 0; i < 5; i++) begin
            if (!low_dev_oe_n[i])
                shared_data_low[i] = low_dev_out[i];
            else if (!low_host_oe_n[i])
                shared_data_low[i] = low_host_out[i];
            else
                shared_data_low[i] = 1'b0;
        end
    end
    modport device (
        input  receive_enable, transmit_enable, conv_clk, dac_data_msb,
               dac_data_bit_five, shared_data_low,
        output low_dev_out, low_dev_oe_n
    );
    modport host (
        output receive_enable, transmit_enable, conv_clk, dac_data_msb,
               dac_data_bit_five, low_host_out, low_host_oe_n,
        input  shared_data_low
    );
endinterface

// file: src/tdd_converter_host.sv
`timescale 1ns/1ps
module tdd_converter_host
    import tdd_port_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_n,
    tdd_port_if.host        port,
    input  wire op_mode_t   mode_req,
    input  wire logic [6:0] tx_word,
    output logic            tx_taken,
    output logic [4:0]      rx_code,
    output logic            rx_valid,
    output logic            link_ready
);
    logic [2:0]  div_reg;
    logic        clk_reg;
    logic        half;
    logic [1:0]  en_reg;
    logic [6:0]  word_reg;
    logic [4:0]  oe_n_reg;
    logic [15:0] wake_cnt_reg;

    assign half = (div_reg == 3'(CONV_DIV / 2 - 1));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            div_reg <= 3'h0;
        else
            div_reg <= half ? 3'h0 : div_reg + 3'h1;
    end

    // clock kept running in shutdown; the device tolerates it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            clk_reg <= 1'b0;
        else if (half)
            clk_reg <= ~clk_reg;
    end
    assign port.conv_clk = clk_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            en_reg <= 2'b00;
        else
            case (mode_req)
                MODE_RECEIVE:  en_reg <= 2'b10;
                MODE_TRANSMIT: en_reg <= 2'b01;
                default:       en_reg <= 2'b00;
            endcase
    end
    assign port.receive_enable  = en_reg[1];
    assign port.transmit_enable = en_reg[0];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            wake_cnt_reg <= 16'h0000;
        else if (en_reg[1] == en_reg[0])
            wake_cnt_reg <= 16'h0000;
        else if (wake_cnt_reg != 16'(WAKE_CYCLES))
            wake_cnt_reg <= wake_cnt_reg + 16'h0001;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            link_ready <= 1'b0;
        else
            link_ready <= (en_reg[1] != en_reg[0]) &&
                          (wake_cnt_reg == 16'(WAKE_CYCLES));
    end

    // new word set up while the converter clock is high, ahead of its fall
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            word_reg <= DAC_ZERO;
            tx_taken <= 1'b0;
        end else begin
            tx_taken <= 1'b0;
            if (half && !clk_reg && en_reg == 2'b01) begin
                word_reg <= tx_word;
                tx_taken <= 1'b1;
            end
        end
    end
    assign port.dac_data_msb      = word_reg[6];
    assign port.dac_data_bit_five = word_reg[5];
    assign port.low_host_out      = (en_reg == 2'b01) ? word_reg[4:0] : 5'h00;

    // drive low lines in transmit and shutdown; low in shutdown, released in receive
    // stays released one cycle after receive, so the device lets go on the same edge the host drives again
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            oe_n_reg <= 5'h00;
        else
            oe_n_reg <= (mode_req == MODE_RECEIVE || en_reg == 2'b10) ? 5'h1F : 5'h00;
    end
    assign port.low_host_oe_n = oe_n_reg;

    // receive code captured on the converter clock fall, away from its update
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_code  <= ADC_ZERO;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (half && clk_reg && en_reg == 2'b10 && link_ready) begin
                rx_code  <= port.shared_data_low;
                rx_valid <= 1'b1;
            end
        end
    end
endmodule

// file: bench/tdd_port_monitor.sv
`timescale 1ns/1ps
module tdd_port_monitor (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       receive_enable,
    input wire logic       transmit_enable,
    input wire logic       conv_clk,
    input wire logic       dac_data_msb,
    input wire logic       dac_data_bit_five,
    input wire logic [4:0] low_host_oe_n,
    input wire logic [4:0] low_dev_oe_n,
    input wire logic [4:0] low_dev_out,
    input wire logic [4:0] shared_data_low
);
    logic rx;
    logic tx;
    logic sd;
    assign rx = receive_enable & ~transmit_enable;
    assign tx = transmit_enable & ~receive_enable;
    assign sd = receive_enable == transmit_enable;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // three cycles leave room for the registered mode decode
    property p_off_free; !rx [*3] |-> low_dev_oe_n == 5'h1F; endproperty
    a_off_free: assert property (p_off_free) else $error("bus held");
    property p_rx_drive; rx [*3] |-> low_dev_oe_n == 5'h00; endproperty
    a_rx_drive: assert property (p_rx_drive) else $error("rx not driven");
    property p_host_free; rx && $past(rx) |-> low_host_oe_n == 5'h1F; endproperty
    a_host_free: assert property (p_host_free) else $error("host drives in rx");
    property p_tx_host; tx && $past(tx) |-> low_host_oe_n == 5'h00; endproperty
    a_tx_host: assert property (p_tx_host) else $error("host idle in tx");
    property p_sd_low; sd [*3] |-> shared_data_low == 5'h00; endproperty
    a_sd_low: assert property (p_sd_low) else $error("lines high");
    property p_rx_rise; rx && $past(rx) && $changed(low_dev_out) |-> conv_clk; endproperty
    a_rx_rise: assert property (p_rx_rise) else $error("code moved on low");
    property p_clk_high; $rose(conv_clk) |-> conv_clk [*4] ##1 !conv_clk; endproperty
    a_clk_high: assert property (p_clk_high) else $error("bad clock high");
    property p_tx_hold;
        tx && $past(tx) && $fell(conv_clk)
            |-> $stable({dac_data_msb, dac_data_bit_five, shared_data_low});
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("word moved");
    c_tx: cover property (tx && $fell(conv_clk));
    c_rx: cover property (rx && $changed(low_dev_out));
    c_sd: cover property (sd ##1 !sd);
endmodule

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    import tdd_port_pkg::*;
    logic              mclk;
    logic              rst_n;
    op_mode_t          mode_req;
    logic [6:0]        tx_word;
    logic signed [4:0] adc_analog_code;
    logic signed [6:0] dac_analog_level;
    logic              dac_active;
    logic              adc_active;
    logic              device_ready;
    logic [4:0]        rx_code;
    logic              rx_valid;
    logic              link_ready;
    logic              tx_taken;
    int                fail_count = 0;
    int                samples_checked = 0;
    logic [6:0]        tx_tab [5] = '{7'h3F, 7'h40, 7'h00, 7'h2A, 7'h15};
    logic [4:0]        rx_tab [5] = '{5'h0F, 5'h10, 5'h1F, 5'h00, 5'h0A};
    tdd_port_if link ();
    tdd_converter_device i_tdd_converter_device (.mclk, .rst_n, .port(link), .adc_analog_code,
        .dac_analog_level, .dac_active, .adc_active, .device_ready);
    tdd_converter_host i_tdd_converter_host (.mclk, .rst_n, .port(link), .mode_req, .tx_word,
        .tx_taken, .rx_code, .rx_valid, .link_ready);
    tdd_port_monitor mon (.mclk, .rst_n, .receive_enable(link.receive_enable),
        .transmit_enable(link.transmit_enable), .conv_clk(link.conv_clk),
        .dac_data_msb(link.dac_data_msb), .dac_data_bit_five(link.dac_data_bit_five),
        .low_host_oe_n(link.low_host_oe_n), .low_dev_oe_n(link.low_dev_oe_n),
        .low_dev_out(link.low_dev_out), .shared_data_low(link.shared_data_low));
    task automatic check(input logic [6:0] seen, input logic [6:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t ns: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (fail_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // wake count runs from the registered enables, not the request, so a few cycles of host latency are allowed
    task automatic go(input op_mode_t m);
        int n;
        mode_req = m;
        for (n = 0; n < 700 && !(device_ready === 1'b1 && link_ready === 1'b1); n++) begin
            @(negedge mclk);
        end
        check(7'(n <= WAKE_CYCLES + 4), 7'h01);
        check({dac_active, adc_active}, (m == MODE_TRANSMIT) ? 7'h02 : 7'h01);
    endtask
    task automatic send(input logic [6:0] w);
        tx_word = w;
        for (int n = 0; n < 40 && dac_analog_level !== w; n++) begin
            @(negedge mclk);
        end
        check(dac_analog_level, w);
        check({link.dac_data_msb, link.dac_data_bit_five, link.shared_data_low}, w);
        for (int n = 0; n < 10 && tx_taken !== 1'b1; n++) begin
            @(negedge mclk);
        end
        check(7'(tx_taken), 7'h01);
    endtask
    task automatic recv(input logic [4:0] c);
        adc_analog_code = c;
        for (int n = 0; n < 40 && !(rx_valid === 1'b1 && rx_code === c); n++) begin
            @(negedge mclk);
        end
        check(rx_code, c);
        check(link.shared_data_low, c);
    endtask
    task automatic shut();
        mode_req = MODE_SHUTDOWN;
        repeat (12) @(negedge mclk);
        check(link.receive_enable ^ link.transmit_enable, 7'h00);
        check({dac_active, adc_active, device_ready}, 7'h00);
        check(dac_analog_level, 7'h00);
        check(link.low_dev_oe_n, 7'h1F);
        check(link.shared_data_low, 7'h00);
    endtask
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        #40000;
        fail_count++;
        print_verdict();
    end
    initial begin
        rst_n = 1'b0;
        mode_req = MODE_SHUTDOWN;
        tx_word = 7'h00;
        adc_analog_code = 5'h00;
        repeat (12) @(negedge mclk);
        check(link.low_dev_oe_n, 7'h1F);
        rst_n = 1'b1;
        go(MODE_TRANSMIT);
        foreach (tx_tab[i]) begin
            send(tx_tab[i]);
        end
        shut();
        go(MODE_RECEIVE);
        check(dac_analog_level, 7'h00);
        foreach (rx_tab[i]) begin
            recv(rx_tab[i]);
        end
        shut();
        go(MODE_TRANSMIT);
        send(7'h55);
        print_verdict();
    end
endmodule
